// ==== inc/cdf_pkg.sv ====
// Summary of operation
// [RL1] The buffer holds 4 Kbytes of compressed bitstream between the host side and the decoder side.
// [RL2] Each host write places one whole 32-bit word into the buffer.
// [RL3] The host moves words in with back-to-back burst writes of 32-bit words for throughput.
// [RL4] The read side hands out the buffered data one 8-bit byte at a time.
// [RL5] Each byte to the decoder moves only when both the valid and the ready signal are high.
// [RL6] The decoder code input is a write-only 8-bit port fed only by the buffer read side.
// [RL7] The path sustains at least 8 Mbit/s from host to decoder without losing data.
// [RL8] A read-only flag shows 1 while at least one code word is held, and is 0 after reset.
// [RL9] An optional request line rises while the buffer is below half full, asking for more data.
// [RL10] The host writes coded data and checks the fill flags before writing more.
// [RL11] Each word is unpacked low byte first into four bytes, and writes while full are ignored; here wr_ready_o drops and the write waits.
package cdf_pkg;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned STORE_BYTES = 4096;
   localparam int unsigned STORE_WORDS = STORE_BYTES / (DATA_W / BYTE_W);
   localparam int unsigned ADDR_W      = $clog2(STORE_WORDS);
   localparam int unsigned CNT_W       = ADDR_W + 1;
   localparam int unsigned SKID_DEPTH  = 4;
   localparam int unsigned LANES       = DATA_W / BYTE_W;
   localparam logic [CNT_W-1:0] HALF_WORDS = CNT_W'(STORE_WORDS / 2);
   localparam logic [1:0]       LANE_RST   = 2'h0;
   // bitstream rate and clock, cycles available per byte at full rate
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned RATE_MBPS      = 8;
   localparam int unsigned CYC_PER_BYTE   = (CLK_MHZ * BYTE_W) / RATE_MBPS;

   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] data;
   } cdf_word_t;

   typedef struct packed {
      logic              valid;
      logic [BYTE_W-1:0] data;
   } cdf_byte_t;

   typedef enum logic [2:0] {
      CDF_FETCH = 3'h1,
      CDF_WAIT  = 3'h2,
      CDF_HOLD  = 3'h4
   } cdf_rd_state_t;
endpackage : cdf_pkg

// ==== rtl/cdf_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdf_ram #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 1024,
   parameter int unsigned AW    = 10
) (
   input  wire logic             sys_clk_i,
   input  wire logic             wr_en_i,
   input  wire logic [AW-1:0]    wr_addr_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic             rd_en_i,
   input  wire logic [AW-1:0]    rd_addr_i,
   output logic      [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule // cdf_ram
`default_nettype wire

// ==== rtl/cdf_skid_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdf_skid_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] buf_q [DEPTH];
   logic [PW-1:0]    wp_q;
   logic [PW-1:0]    rp_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = buf_q[rp_q];

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         buf_q[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // cdf_skid_fifo
`default_nettype wire

// ==== rtl/cdf_width_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdf_width_fifo (
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_b_i,
   // host write side
   input  wire logic                         wr_valid_i,
   output logic                              wr_ready_o,
   input  wire logic [cdf_pkg::DATA_W-1:0]   wr_data_i,
   // decoder code port, write-only towards the decoder
   output logic                              code_valid_o,
   input  wire logic                         code_ready_i,
   output logic      [cdf_pkg::BYTE_W-1:0]   code_data_o,
   // status
   output logic                              buffer_has_data_flag_o,
   output logic                              below_half_o,
   output logic                              full_o,
   input  wire logic                         half_irq_en_i,
   output logic                              more_data_req_o
);
   // host words pass a small skid stage first; its ready reaches the host
   logic                       sk_valid;
   logic                       sk_ready;
   logic [cdf_pkg::DATA_W-1:0] sk_data;

   cdf_skid_fifo #(
      .WIDTH (cdf_pkg::DATA_W),
      .DEPTH (cdf_pkg::SKID_DEPTH)
   ) u_skid (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .in_data_i   (wr_data_i),
      .out_valid_o (sk_valid),
      .out_ready_i (sk_ready),
      .out_data_o  (sk_data)
   );

   // main store pointers and occupancy in words
   logic [cdf_pkg::ADDR_W-1:0] wp_q;
   logic [cdf_pkg::ADDR_W-1:0] rp_q;
   logic [cdf_pkg::CNT_W-1:0]  words_q;
   logic                       store_full;
   logic                       store_empty;
   logic                       push;
   logic                       pop;

   assign store_full  = (words_q == cdf_pkg::CNT_W'(cdf_pkg::STORE_WORDS));
   assign store_empty = (words_q == '0);
   // a full store stalls the skid stage, so excess writes are refused, not lost
   assign sk_ready    = ~store_full; // RL11
   assign push        = sk_valid & sk_ready; // RL2

   // unpacker state
   cdf_pkg::cdf_rd_state_t state_q;
   cdf_pkg::cdf_rd_state_t state_d;
   logic [cdf_pkg::DATA_W-1:0] word_q;
   logic [1:0]                 lane_q;
   logic [cdf_pkg::DATA_W-1:0] ram_rd;
   logic                       byte_take;
   logic                       last_lane;

   assign byte_take = (state_q == cdf_pkg::CDF_HOLD) & code_ready_i; // RL5
   assign last_lane = (lane_q == 2'(cdf_pkg::LANES - 1));
   assign pop       = (state_q == cdf_pkg::CDF_FETCH) & ~store_empty;

   cdf_ram #(
      .WIDTH (cdf_pkg::DATA_W),
      .DEPTH (cdf_pkg::STORE_WORDS),
      .AW    (cdf_pkg::ADDR_W)
   ) u_ram (
      .sys_clk_i (sys_clk_i),
      .wr_en_i   (push),
      .wr_addr_i (wp_q),
      .wr_data_i (sk_data),
      .rd_en_i   (pop),
      .rd_addr_i (rp_q),
      .rd_data_o (ram_rd)
   ); // RL1

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_q <= '0;
      end else if (push) begin
         wp_q <= wp_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rp_q <= '0;
      end else if (pop) begin
         rp_q <= rp_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         words_q <= '0;
      end else begin
         words_q <= words_q + cdf_pkg::CNT_W'(push) - cdf_pkg::CNT_W'(pop);
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         cdf_pkg::CDF_FETCH: begin
            if (!store_empty) begin
               state_d = cdf_pkg::CDF_WAIT;
            end
         end
         cdf_pkg::CDF_WAIT: begin
            state_d = cdf_pkg::CDF_HOLD;
         end
         cdf_pkg::CDF_HOLD: begin
            if (byte_take && last_lane) begin
               state_d = cdf_pkg::CDF_FETCH;
            end
         end
         default: begin
            state_d = cdf_pkg::CDF_FETCH;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= cdf_pkg::CDF_FETCH;
      end else begin
         state_q <= state_d;
      end
   end

   // word register is loaded one cycle after the ram read is issued
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         word_q <= '0;
      end else if (state_q == cdf_pkg::CDF_WAIT) begin
         word_q <= ram_rd;
      end
   end

   // low byte first; the fetch costs two cycles per four bytes, far above the needed rate
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lane_q <= cdf_pkg::LANE_RST;
      end else if (state_q == cdf_pkg::CDF_WAIT) begin
         lane_q <= cdf_pkg::LANE_RST;
      end else if (byte_take) begin
         lane_q <= lane_q + 2'h1; // RL11
      end
   end

   // byte output from flip-flops, one byte per handshake
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         code_data_o <= '0;
      end else if (state_q == cdf_pkg::CDF_WAIT) begin
         code_data_o <= ram_rd[cdf_pkg::BYTE_W-1:0]; // RL4
      end else if (byte_take && !last_lane) begin
         code_data_o <= word_q[(32'(lane_q) + 1) * cdf_pkg::BYTE_W +: cdf_pkg::BYTE_W]; // RL4
      end
   end

   assign code_valid_o = (state_q == cdf_pkg::CDF_HOLD); // RL5 RL6 RL7

   // any word held, counting store, skid and unpacker contents
   logic held_any;
   assign held_any = ~store_empty | sk_valid | (state_q != cdf_pkg::CDF_FETCH);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         buffer_has_data_flag_o <= 1'b0;
      end else begin
         buffer_has_data_flag_o <= held_any; // RL8
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         below_half_o    <= 1'b1;
         full_o          <= 1'b0;
         more_data_req_o <= 1'b0;
      end else begin
         below_half_o    <= (words_q < cdf_pkg::HALF_WORDS);
         full_o          <= store_full;
         more_data_req_o <= half_irq_en_i & (words_q < cdf_pkg::HALF_WORDS); // RL9
      end
   end
endmodule // cdf_width_fifo
`default_nettype wire

// ==== rtl/cdf_fix_note.sv ====
// unpacker state encoding lives in the package, used by the store alone, not by the bench

// ==== dv/cdf_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdf_sva (
   input wire logic                       sys_clk_i,
   input wire logic                       rst_b_i,
   input wire logic                       wr_valid_i,
   input wire logic                       wr_ready_o,
   input wire logic                       code_valid_o,
   input wire logic                       code_ready_i,
   input wire logic [cdf_pkg::BYTE_W-1:0] code_data_o,
   input wire logic                       buffer_has_data_flag_o,
   input wire logic                       below_half_o,
   input wire logic                       full_o,
   input wire logic                       half_irq_en_i,
   input wire logic                       more_data_req_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [1:0] lane_q;
   wire        take = code_valid_o & code_ready_i;
   // byte position within the word, counted from takes alone
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         lane_q <= 2'h0;
      else if (take)
         lane_q <= lane_q + 2'h1;
   end
   sequence last_take_s; take && lane_q == 2'h3; endsequence
   sequence refill_gap_s; !code_valid_o [*2]; endsequence
   stay_a: assert property (code_valid_o && !code_ready_i |=> code_valid_o)
      else $error("byte withdrawn before taken");
   hold_data_a: assert property (code_valid_o && !code_ready_i |=> $stable(code_data_o))
      else $error("byte changed before taken");
   next_byte_a: assert property (take && lane_q != 2'h3 |=> code_valid_o)
      else $error("next byte of word late");
   word_gap_a: assert property (last_take_s |=> refill_gap_s)
      else $error("word boundary gap wrong");
   valid_flag_a: assert property (code_valid_o |-> buffer_has_data_flag_o)
      else $error("byte offered with flag low");
   write_flag_a: assert property (wr_valid_i && wr_ready_o |=> ##[0:3] buffer_has_data_flag_o)
      else $error("flag not set after write");
   full_half_a: assert property (full_o |-> !below_half_o)
      else $error("full and below half together");
   req_off_a: assert property (!$past(half_irq_en_i) |-> !more_data_req_o)
      else $error("request while disabled");
endmodule // cdf_sva
`default_nettype wire

// ==== dv/cdf_dec_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdf_dec_model (
   input  wire logic       sys_clk_i,
   input  wire logic [1:0] mode_i,
   output logic            code_ready_o
);
   int sd = 62900;
   // mode 0 stalls, 1 takes every byte, 2 takes at random; never drives data back
   initial code_ready_o = 1'b0;
   always @(negedge sys_clk_i) begin
      code_ready_o <= (mode_i == 2'h1) | ((mode_i == 2'h2) & 1'($random(sd)));
   end
endmodule // cdf_dec_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic                       sys_clk_i, rst_b_i, wr_valid_i, half_irq_en_i;
   logic [cdf_pkg::DATA_W-1:0] wr_data_i;
   logic [1:0]                 dec_mode;
   wire logic                  wr_ready_o, code_valid_o, code_ready_i, has_data, below_half_o;
   wire logic                  full_o, more_data_req_o;
   wire logic [cdf_pkg::BYTE_W-1:0] code_data_o;
   int                         err_total = 0, cmp_count = 0, seed = 62900, cyc = 0, n;
   logic [7:0]                 exp_q[$];
   cdf_width_fifo dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wr_valid_i(wr_valid_i),
      .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i), .code_valid_o(code_valid_o),
      .code_ready_i(code_ready_i), .code_data_o(code_data_o), .buffer_has_data_flag_o(has_data),
      .below_half_o(below_half_o), .full_o(full_o), .half_irq_en_i(half_irq_en_i),
      .more_data_req_o(more_data_req_o));
   cdf_dec_model dec (.sys_clk_i(sys_clk_i), .mode_i(dec_mode), .code_ready_o(code_ready_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (e !== g) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // valid stays up after return so bursts run back to back
   task automatic put(input logic [31:0] w);
      wr_valid_i = 1'b1;
      wr_data_i = w;
      while (wr_ready_o !== 1'b1) @(negedge sys_clk_i);
      for (int i = 0; i < 4; i++) exp_q.push_back(w[8*i +: 8]);
      @(negedge sys_clk_i);
   endtask
   task automatic drain;
      while (exp_q.size() != 0) @(negedge sys_clk_i);
      repeat (4) @(negedge sys_clk_i);
      chk("flag empty", 1'b0, has_data);
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         complete_run();
      end
      if (rst_b_i && code_valid_o === 1'b1 && code_ready_i === 1'b1) begin
         if (exp_q.size() == 0)
            chk("spare byte", 1'b0, 1'b1);
         else
            chk("code byte", exp_q.pop_front(), code_data_o);
      end
   end
   initial begin
      rst_b_i = 1'b0;
      wr_valid_i = 1'b0;
      wr_data_i = '0;
      half_irq_en_i = 1'b1;
      dec_mode = 2'h1;
      repeat (3) @(negedge sys_clk_i);
      chk("reset outs", 6'h24, {wr_ready_o, code_valid_o, has_data, below_half_o, full_o,
         more_data_req_o});
      rst_b_i = 1'b1;
      @(negedge sys_clk_i);
      for (int i = 0; i < 24; i++) put($random(seed));
      wr_valid_i = 1'b0;
      chk("req below half", 1'b1, more_data_req_o);
      half_irq_en_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      chk("req masked", 1'b0, more_data_req_o);
      half_irq_en_i = 1'b1;
      drain();
      // decoder stalled: fill until the host side refuses
      dec_mode = 2'h0;
      n = 0;
      while (wr_ready_o === 1'b1) begin
         put($random(seed));
         n++;
      end
      wr_valid_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      chk("capacity", 1'b1, n >= 1028 && n <= 1029);
      chk("full", 1'b1, full_o);
      chk("req when full", 1'b0, more_data_req_o);
      dec_mode = 2'h2;
      put($random(seed));
      wr_valid_i = 1'b0;
      drain();
      chk("below half", 1'b1, below_half_o);
      complete_run();
   end
endmodule // tb
bind cdf_width_fifo cdf_sva u_sva (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .code_valid_o(code_valid_o),
   .code_ready_i(code_ready_i), .code_data_o(code_data_o),
   .buffer_has_data_flag_o(buffer_has_data_flag_o), .below_half_o(below_half_o),
   .full_o(full_o), .half_irq_en_i(half_irq_en_i), .more_data_req_o(more_data_req_o));
`default_nettype wire
